// *** uml_top.sv ***
// serial transceiver: host register decode, queues, framing and modem lines
`timescale 1ns/100ps
`default_nettype none

module uml_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       ce,
	input  wire logic                       clr,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [WIDTH-1:0]                out_data,
	output logic [$clog2(DEPTH+1)-1:0]      count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [CW-1:0]               cnt;
	} uml_fifo_st_t;
	uml_fifo_st_t st_q, st_d;
	logic push, pop;

	assign in_ready  = (st_q.cnt != CW'(DEPTH));
	assign out_valid = (st_q.cnt != '0);
	assign out_data  = st_q.mem[st_q.rp];
	assign count     = st_q.cnt;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		st_d = st_q;
		if (clr) begin
			st_d.wp  = '0;
			st_d.rp  = '0;
			st_d.cnt = '0;
		end else begin
			if (push) begin
				st_d.mem[st_q.wp] = in_data;
				st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + 1'b1;
			end
			if (pop) begin
				st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + 1'b1;
			end
			if (push && !pop) begin
				st_d.cnt = st_q.cnt + 1'b1;
			end else if (pop && !push) begin
				st_d.cnt = st_q.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
		end
	end
endmodule

module uml_top (
	input  wire logic                        CLOCK,
	input  wire logic                        RESETN,
	input  wire logic                        CE,
	input  wire logic                        CS_N,
	input  wire logic                        RD_N,
	input  wire logic                        WR_N,
	input  wire logic [uml_pkg::SEL_W-1:0]   SEL,
	input  wire logic [uml_pkg::DATA_W-1:0]  DIN,
	output logic [uml_pkg::DATA_W-1:0]       DOUT,
	output logic                             DOUT_OE,
	input  wire logic                        RX,
	output logic                             TX,
	input  wire logic                        CTS_N,
	input  wire logic                        DSR_N,
	input  wire logic                        RI_N,
	input  wire logic                        CD_N,
	output logic                             DTR_N,
	output logic                             RTS_N,
	output logic                             INT
);
	import uml_pkg::*;

	typedef struct packed {
		logic [2:0]  rd_s;
		logic [2:0]  wr_s;
		logic [2:0]  sel_s1;
		logic [2:0]  sel_s2;
		logic [7:0]  din_s1;
		logic [7:0]  din_s2;
		logic [4:0]  pin_s1;
		logic [4:0]  pin_s2;
		logic [3:0]  stat_prev;
		logic [7:0]  line_control;
		logic [7:0]  modem_control;
		logic [7:0]  interrupt_enable;
		logic [7:0]  scr;
		logic [7:0]  dll;
		logic [7:0]  divisor_high;
		logic        q_en;
		logic [1:0]  trig;
		logic        err_ovr;
		logic        err_par;
		logic        err_frm;
		logic [3:0]  msr_dl;
		logic [15:0] baud;
		uml_ser_t    tx_st;
		logic [3:0]  tx_tick;
		logic [2:0]  tx_bitn;
		logic [7:0]  tx_sh;
		logic        tx_par;
		logic        tx_bit;
		logic        tx_stop2;
		uml_ser_t    rx_st;
		logic [3:0]  rx_tick;
		logic [2:0]  rx_bitn;
		logic [7:0]  rx_sh;
		logic        rx_par;
		logic        rx_pe;
		logic        tx_pin;
		logic        dtr_n;
		logic        rts_n;
		logic        int_o;
		logic [7:0]  dout;
		logic        dout_oe;
	} uml_st_t;

	uml_st_t     st_q, st_d;
	logic        rd_fire, wr_fire, dlab, loop, tick, line_in;
	logic [2:0]  rsel;
	logic [7:0]  wdat, rd_val, line_status, modem_status, interrupt_status;
	logic [3:0]  stat, isr_code;
	logic [2:0]  last_bit;
	logic        txq_in_valid, txq_in_ready, txq_valid, txq_pop;
	logic        rxq_push, rxq_in_ready, rxq_valid, rxq_pop, rx_clr, tx_clr;
	logic [7:0]  txq_data, rxq_data, rx_word;
	logic [CNT_W-1:0] txq_cnt, rxq_cnt;
	logic        rx_done;

	function automatic logic [7:0] mask_len(input logic [7:0] d, input logic [1:0] wl);
		mask_len = d & (8'hFF >> (2'd3 - wl));
	endfunction

	function automatic logic [4:0] trig_level(input logic [1:0] s);
		case (s)
			2'd0: trig_level = TRIG_0;
			2'd1: trig_level = TRIG_1;
			2'd2: trig_level = TRIG_2;
			default: trig_level = TRIG_3;
		endcase
	endfunction

	// queues hold 16 bytes each; a write to a full transmit queue is dropped
	uml_fifo #(.WIDTH(DATA_W), .DEPTH(QUEUE_DEPTH)) u_txq (
		.clk       (CLOCK),
		.rst_n     (RESETN),
		.ce        (CE),
		.clr       (tx_clr),
		.in_valid  (txq_in_valid),
		.in_ready  (txq_in_ready),
		.in_data   (wdat),
		.out_valid (txq_valid),
		.out_ready (txq_pop),
		.out_data  (txq_data),
		.count     (txq_cnt)
	);

	uml_fifo #(.WIDTH(DATA_W), .DEPTH(QUEUE_DEPTH)) u_rxq (
		.clk       (CLOCK),
		.rst_n     (RESETN),
		.ce        (CE),
		.clr       (rx_clr),
		.in_valid  (rxq_push),
		.in_ready  (rxq_in_ready),
		.in_data   (rx_word),
		.out_valid (rxq_valid),
		.out_ready (rxq_pop),
		.out_data  (rxq_data),
		.count     (rxq_cnt)
	);

	// host strobes act on the edge seen after two synchroniser stages
	assign rd_fire  = st_q.rd_s[1] & ~st_q.rd_s[2];
	assign wr_fire  = st_q.wr_s[1] & ~st_q.wr_s[2];
	assign rsel     = st_q.sel_s2;
	assign wdat     = st_q.din_s2;
	assign dlab     = st_q.line_control[LCR_DIV_BIT];
	assign loop     = st_q.modem_control[MCR_LOOP_BIT];
	assign last_bit = 3'd4 + {1'b0, st_q.line_control[1:0]};
	assign tick     = (st_q.baud == 16'h0000);
	// status order: cts, dsr, ri, cd; loop-back feeds them from modem control
	assign stat = loop ? {st_q.modem_control[MCR_RTS_BIT], st_q.modem_control[MCR_TRDY_BIT],
		st_q.modem_control[MCR_OUT1_BIT], st_q.modem_control[MCR_OUT2_BIT]} : ~st_q.pin_s2[3:0];
	assign line_in  = loop ? st_q.tx_bit : st_q.pin_s2[4];
	assign txq_in_valid = wr_fire && rsel == SEL_DATA && !dlab;
	assign rxq_pop  = rd_fire && rsel == SEL_DATA && !dlab;
	assign tx_clr   = wr_fire && rsel == SEL_ISR_QCR && wdat[QCR_TXCL_BIT];
	assign rx_clr   = wr_fire && rsel == SEL_ISR_QCR && wdat[QCR_RXCL_BIT];
	assign txq_pop  = (st_q.tx_st == UML_IDLE) && txq_valid;
	assign rx_done  = (st_q.rx_st == UML_STOP) && tick && st_q.rx_tick == LAST_TICK;
	assign rxq_push = rx_done;
	assign rx_word  = st_q.rx_sh >> (2'd3 - st_q.line_control[1:0]);

	always_comb begin
		line_status = {1'b0, !txq_valid && st_q.tx_st == UML_IDLE, !txq_valid, 1'b0,
			st_q.err_frm, st_q.err_par, st_q.err_ovr, rxq_valid};
		modem_status = {stat[0], stat[1], stat[2], stat[3], st_q.msr_dl};
		if (st_q.interrupt_enable[2] && (st_q.err_ovr || st_q.err_par || st_q.err_frm)) begin
			isr_code = ISR_LINE;
		end else if (st_q.interrupt_enable[0] && (st_q.q_en ? rxq_cnt >= trig_level(st_q.trig)
			: rxq_valid)) begin
			isr_code = ISR_RXDATA;
		end else if (st_q.interrupt_enable[1] && !txq_valid) begin
			isr_code = ISR_THRE;
		end else if (st_q.interrupt_enable[3] && |st_q.msr_dl) begin
			isr_code = ISR_MODEM;
		end else begin
			isr_code = ISR_NONE;
		end
		interrupt_status = {st_q.q_en, st_q.q_en, 2'b00, isr_code};
		if (rsel == SEL_DATA) begin
			rd_val = dlab ? st_q.dll : rxq_data;
		end else if (rsel == SEL_IER) begin
			rd_val = dlab ? st_q.divisor_high : st_q.interrupt_enable;
		end else if (rsel == SEL_ISR_QCR) begin
			rd_val = interrupt_status;
		end else if (rsel == SEL_LCR) begin
			rd_val = st_q.line_control;
		end else if (rsel == SEL_MCR) begin
			rd_val = st_q.modem_control;
		end else if (rsel == SEL_LSR) begin
			rd_val = line_status;
		end else if (rsel == SEL_MSR) begin
			rd_val = modem_status;
		end else begin
			rd_val = st_q.scr;
		end
	end

	always_comb begin
		st_d = st_q;
		st_d.rd_s   = {st_q.rd_s[1:0], ~RD_N & ~CS_N};
		st_d.wr_s   = {st_q.wr_s[1:0], ~WR_N & ~CS_N};
		st_d.sel_s1 = SEL;
		st_d.sel_s2 = st_q.sel_s1;
		st_d.din_s1 = DIN;
		st_d.din_s2 = st_q.din_s1;
		st_d.pin_s1 = {RX, CTS_N, DSR_N, RI_N, CD_N};
		st_d.pin_s2 = st_q.pin_s1;
		st_d.stat_prev = stat;
		st_d.baud = tick ? (({st_q.divisor_high, st_q.dll} == 16'h0000) ? 16'h0000
			: {st_q.divisor_high, st_q.dll} - 16'h0001) : st_q.baud - 16'h0001;
		// clears on read first, so a same-cycle event below still sets
		if (rd_fire && rsel == SEL_LSR) begin
			st_d.err_ovr = 1'b0;
			st_d.err_par = 1'b0;
			st_d.err_frm = 1'b0;
		end
		if (rd_fire && rsel == SEL_MSR) begin
			st_d.msr_dl = 4'h0;
		end
		if (stat[3] != st_q.stat_prev[3]) begin
			st_d.msr_dl[0] = 1'b1;
		end
		if (stat[2] != st_q.stat_prev[2]) begin
			st_d.msr_dl[1] = 1'b1;
		end
		if (!stat[1] && st_q.stat_prev[1]) begin
			st_d.msr_dl[2] = 1'b1;
		end
		if (stat[0] != st_q.stat_prev[0]) begin
			st_d.msr_dl[3] = 1'b1;
		end
		// divisor bytes are untouched by any other write
		if (wr_fire) begin
			if (rsel == SEL_DATA && dlab) begin
				st_d.dll = wdat;
			end else if (rsel == SEL_IER) begin
				if (dlab) begin
					st_d.divisor_high = wdat;
				end else begin
					st_d.interrupt_enable = {4'h0, wdat[3:0]};
				end
			end else if (rsel == SEL_ISR_QCR) begin
				st_d.q_en = wdat[QCR_EN_BIT];
				st_d.trig = wdat[7:6];
			end else if (rsel == SEL_LCR) begin
				st_d.line_control = wdat;
			end else if (rsel == SEL_MCR) begin
				st_d.modem_control = {3'b000, wdat[4:0]};
			end else if (rsel == SEL_SCR) begin
				st_d.scr = wdat;
			end
		end
		// a new divisor restarts the rate counter, else an old long count must run out first
		if (wr_fire && dlab && (rsel == SEL_DATA || rsel == SEL_IER)) begin
			st_d.baud = 16'h0000;
		end
		case (st_q.tx_st)
			UML_IDLE: begin
				st_d.tx_bit = 1'b1;
				if (txq_valid) begin
					st_d.tx_sh    = mask_len(txq_data, st_q.line_control[1:0]);
					st_d.tx_par   = ^mask_len(txq_data, st_q.line_control[1:0])
						^ ~st_q.line_control[LCR_EVEN_BIT];
					st_d.tx_tick  = 4'h0;
					st_d.tx_bit   = 1'b0;
					st_d.tx_stop2 = 1'b0;
					st_d.tx_st    = UML_START;
				end
			end
			UML_START: begin
				if (tick) begin
					st_d.tx_tick = st_q.tx_tick + 4'h1;
					if (st_q.tx_tick == LAST_TICK) begin
						st_d.tx_bit  = st_q.tx_sh[0];
						st_d.tx_bitn = 3'd0;
						st_d.tx_st   = UML_DATA;
					end
				end
			end
			UML_DATA: begin
				if (tick) begin
					st_d.tx_tick = st_q.tx_tick + 4'h1;
					if (st_q.tx_tick == LAST_TICK) begin
						st_d.tx_sh   = st_q.tx_sh >> 1;
						st_d.tx_bitn = st_q.tx_bitn + 3'd1;
						st_d.tx_bit  = st_q.tx_sh[1];
						if (st_q.tx_bitn == last_bit) begin
							st_d.tx_bit = st_q.line_control[LCR_PAR_BIT] ? st_q.tx_par : 1'b1;
							st_d.tx_st  = st_q.line_control[LCR_PAR_BIT] ? UML_PAR : UML_STOP;
						end
					end
				end
			end
			UML_PAR: begin
				if (tick) begin
					st_d.tx_tick = st_q.tx_tick + 4'h1;
					if (st_q.tx_tick == LAST_TICK) begin
						st_d.tx_bit = 1'b1;
						st_d.tx_st  = UML_STOP;
					end
				end
			end
			default: begin
				st_d.tx_bit = 1'b1;
				if (tick) begin
					st_d.tx_tick = st_q.tx_tick + 4'h1;
					if (st_q.tx_tick == LAST_TICK) begin
						// second stop bit when selected; 1.5 stop bits send as two
						if (st_q.line_control[LCR_STOP_BIT] && !st_q.tx_stop2) begin
							st_d.tx_stop2 = 1'b1;
						end else begin
							st_d.tx_st = UML_IDLE;
						end
					end
				end
			end
		endcase
		case (st_q.rx_st)
			UML_IDLE: begin
				// a high line carries nothing; only a low level starts a frame
				if (!line_in) begin
					st_d.rx_tick = 4'h0;
					st_d.rx_par  = ~st_q.line_control[LCR_EVEN_BIT];
					st_d.rx_st   = UML_START;
				end
			end
			UML_START: begin
				if (tick) begin
					st_d.rx_tick = st_q.rx_tick + 4'h1;
					if (st_q.rx_tick == MID_TICK) begin
						st_d.rx_tick = 4'h0;
						st_d.rx_bitn = 3'd0;
						st_d.rx_pe   = 1'b0;
						st_d.rx_st   = line_in ? UML_IDLE : UML_DATA;
					end
				end
			end
			UML_DATA: begin
				if (tick) begin
					st_d.rx_tick = st_q.rx_tick + 4'h1;
					if (st_q.rx_tick == LAST_TICK) begin
						st_d.rx_sh   = {line_in, st_q.rx_sh[7:1]};
						st_d.rx_par  = st_q.rx_par ^ line_in;
						st_d.rx_bitn = st_q.rx_bitn + 3'd1;
						if (st_q.rx_bitn == last_bit) begin
							st_d.rx_st = st_q.line_control[LCR_PAR_BIT] ? UML_PAR : UML_STOP;
						end
					end
				end
			end
			UML_PAR: begin
				if (tick) begin
					st_d.rx_tick = st_q.rx_tick + 4'h1;
					if (st_q.rx_tick == LAST_TICK) begin
						st_d.rx_pe = st_q.rx_par ^ line_in;
						st_d.rx_st = UML_STOP;
					end
				end
			end
			default: begin
				if (tick) begin
					st_d.rx_tick = st_q.rx_tick + 4'h1;
					if (st_q.rx_tick == LAST_TICK) begin
						st_d.rx_st = UML_IDLE;
						if (!rxq_in_ready) begin
							st_d.err_ovr = 1'b1;
						end
						if (st_q.rx_pe) begin
							st_d.err_par = 1'b1;
						end
						if (!line_in) begin
							st_d.err_frm = 1'b1;
						end
					end
				end
			end
		endcase
		st_d.tx_pin  = st_d.modem_control[MCR_LOOP_BIT] ? 1'b1 : st_d.tx_bit;
		st_d.dtr_n   = ~st_d.modem_control[MCR_TRDY_BIT];
		st_d.rts_n   = ~st_d.modem_control[MCR_RTS_BIT];
		st_d.int_o   = (isr_code != ISR_NONE);
		st_d.dout_oe = st_q.rd_s[1];
		if (rd_fire) begin
			st_d.dout = rd_val;
		end
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			st_q         <= '0;
			st_q.rd_s    <= 3'b000;
			st_q.line_control     <= LCR_RST;
			st_q.modem_control     <= MCR_RST;
			st_q.interrupt_enable     <= IER_RST;
			st_q.scr     <= SCR_RST;
			st_q.dll     <= DIV_RST;
			st_q.divisor_high     <= DIV_RST;
			st_q.tx_st   <= UML_IDLE;
			st_q.rx_st   <= UML_IDLE;
			st_q.tx_bit  <= 1'b1;
			st_q.tx_pin  <= 1'b1;
			st_q.dtr_n   <= 1'b1;
			st_q.rts_n   <= 1'b1;
			st_q.pin_s1  <= 5'h1F;
			st_q.pin_s2  <= 5'h1F;
		end else if (CE) begin
			st_q <= st_d;
		end
	end

	assign TX      = st_q.tx_pin;
	assign DTR_N   = st_q.dtr_n;
	assign RTS_N   = st_q.rts_n;
	assign INT     = st_q.int_o;
	assign DOUT    = st_q.dout;
	assign DOUT_OE = st_q.dout_oe;

	chk_trdy_write : assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		(CE && wr_fire && rsel == SEL_MCR) |=> (DTR_N == !$past(wdat[0])))
		else $error("terminal ready does not follow modem control bit 0");
	chk_rts_write : assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		(CE && wr_fire && rsel == SEL_MCR) |=> (RTS_N == !$past(wdat[1])))
		else $error("request to send does not follow modem control bit 1");
	chk_loop_tx_high : assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		st_q.modem_control[MCR_LOOP_BIT] |-> TX)
		else $error("transmit pin not high in loop-back");
	chk_idle_tx_high : assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		(st_q.tx_st == UML_IDLE) |-> TX)
		else $error("transmit pin not high while idle");
	chk_ring_event : assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		(CE && !loop && st_q.pin_s2[1] && st_q.stat_prev[1]) |=> st_q.msr_dl[2])
		else $error("ring indicator rise not flagged");
	chk_cts_status : assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		(CE && rd_fire && rsel == SEL_MSR && !loop) |=> (DOUT[MSR_CTS_BIT] == !$past(st_q.pin_s2[3])))
		else $error("modem status bit 4 does not show clear to send");
	chk_div_low_read : assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		(CE && rd_fire && rsel == SEL_DATA && dlab) |=> (DOUT == $past(st_q.dll)))
		else $error("divisor low byte not returned at code 0");
	chk_div_kept : assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		(CE && wr_fire && rsel == SEL_LCR) |=> ($stable(st_q.dll) && $stable(st_q.divisor_high)))
		else $error("divisor changed by a line control write");
	chk_reserved_wr : assert property (
		@(posedge CLOCK) disable iff (!RESETN)
		(CE && wr_fire && (rsel == SEL_LSR || rsel == SEL_MSR))
			|=> ($stable(st_q.scr) && $stable(st_q.modem_control) && $stable(st_q.line_control)))
		else $error("reserved write changed a register");
endmodule

`default_nettype wire

// *** uml_pkg.sv ***
// constants and types shared by the serial transceiver register block
package uml_pkg;
	localparam int          SEL_W        = 3;
	localparam int          DATA_W       = 8;
	localparam int          QUEUE_DEPTH  = 16;
	localparam int          CNT_W        = 5;
	localparam logic [2:0]  SEL_DATA     = 3'h0;
	localparam logic [2:0]  SEL_IER      = 3'h1;
	localparam logic [2:0]  SEL_ISR_QCR  = 3'h2;
	localparam logic [2:0]  SEL_LCR      = 3'h3;
	localparam logic [2:0]  SEL_MCR      = 3'h4;
	localparam logic [2:0]  SEL_LSR      = 3'h5;
	localparam logic [2:0]  SEL_MSR      = 3'h6;
	localparam logic [2:0]  SEL_SCR      = 3'h7;
	localparam int          LCR_STOP_BIT = 2;
	localparam int          LCR_PAR_BIT  = 3;
	localparam int          LCR_EVEN_BIT = 4;
	localparam int          LCR_DIV_BIT  = 7;
	localparam int          MCR_TRDY_BIT = 0;
	localparam int          MCR_RTS_BIT  = 1;
	localparam int          MCR_OUT1_BIT = 2;
	localparam int          MCR_OUT2_BIT = 3;
	localparam int          MCR_LOOP_BIT = 4;
	localparam int          MSR_CTS_BIT  = 4;
	localparam int          QCR_EN_BIT   = 0;
	localparam int          QCR_RXCL_BIT = 1;
	localparam int          QCR_TXCL_BIT = 2;
	localparam logic [7:0]  LCR_RST      = 8'h00;
	localparam logic [7:0]  MCR_RST      = 8'h00;
	localparam logic [7:0]  IER_RST      = 8'h00;
	localparam logic [7:0]  SCR_RST      = 8'h00;
	localparam logic [7:0]  DIV_RST      = 8'h00;
	localparam logic [3:0]  LAST_TICK    = 4'hF;
	localparam logic [3:0]  MID_TICK     = 4'h7;
	localparam logic [3:0]  ISR_NONE     = 4'h1;
	localparam logic [3:0]  ISR_LINE     = 4'h6;
	localparam logic [3:0]  ISR_RXDATA   = 4'h4;
	localparam logic [3:0]  ISR_THRE     = 4'h2;
	localparam logic [3:0]  ISR_MODEM    = 4'h0;
	localparam logic [4:0]  TRIG_0       = 5'h01;
	localparam logic [4:0]  TRIG_1       = 5'h04;
	localparam logic [4:0]  TRIG_2       = 5'h08;
	localparam logic [4:0]  TRIG_3       = 5'h0E;
	typedef enum logic [2:0] {
		UML_IDLE  = 3'b000,
		UML_START = 3'b001,
		UML_DATA  = 3'b011,
		UML_PAR   = 3'b010,
		UML_STOP  = 3'b110
	} uml_ser_t;
endpackage

// *** uml_modem.sv ***
// serial line partner: frames bytes onto rx and captures frames from tx
`timescale 1ns/100ps
`default_nettype none
module uml_modem (
	input  wire logic clk,
	input  wire logic tx,
	input  wire logic par_en,
	output logic      rx
);
	logic [7:0] got_q[$];
	logic       err_q[$];
	logic [7:0] b;
	logic       e;
	initial rx = 1'b1;
	// even parity; bad flips it so the receiver has something to catch
	task automatic send_byte(input logic [7:0] d, input logic bad);
		logic [10:0] f;
		f = par_en ? {1'b1, ^d ^ bad, d, 1'b0} : {2'b11, d, 1'b0};
		for (int i = 0; i < (par_en ? 11 : 10); i++) begin
			@(posedge clk);
			#1;
			rx = f[i];
			repeat (15) @(posedge clk);
		end
	endtask
	// sample mid-bit, eight ticks after the start edge
	always begin
		@(negedge tx);
		repeat (8) @(posedge clk);
		if (tx === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (16) @(posedge clk);
				b[i] = tx;
			end
			e = 1'b0;
			if (par_en) begin
				repeat (16) @(posedge clk);
				e = (tx !== ^b);
			end
			repeat (16) @(posedge clk);
			e = e | (tx !== 1'b1);
			got_q.push_back(b);
			err_q.push_back(e);
		end
	end
endmodule
`default_nettype wire

// *** uml_top_tb_top.sv ***
// self-checking bench for the serial transceiver register block
`timescale 1ns/100ps
`default_nettype none
module uml_top_tb_top;
	logic       CLOCK, RESETN, CS_N, RD_N, WR_N, RX, TX, CTS_N, DSR_N, RI_N, CD_N;
	logic       DTR_N, RTS_N, INT, DOUT_OE, par_en;
	logic [2:0] SEL;
	logic [7:0] DIN, DOUT, q;
	int         fail_count, num_checks;
	// clock enable tied high: freezing is outside what this bench judges
	uml_top i_dut (.CLOCK(CLOCK), .RESETN(RESETN), .CE(1'b1), .CS_N(CS_N), .RD_N(RD_N),
		.WR_N(WR_N), .SEL(SEL), .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .RX(RX), .TX(TX),
		.CTS_N(CTS_N), .DSR_N(DSR_N), .RI_N(RI_N), .CD_N(CD_N), .DTR_N(DTR_N),
		.RTS_N(RTS_N), .INT(INT));
	uml_modem m (.clk(CLOCK), .tx(TX), .par_en(par_en), .rx(RX));
	always #5 CLOCK = ~CLOCK;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] x);
		num_checks++;
		if (s !== x) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask
	// strobes pass two sync flops, so hold select and data well around them
	task automatic bus(input logic [2:0] s, input logic w, input logic [7:0] d);
		SEL = s;
		DIN = d;
		cyc(3);
		CS_N = 1'b0;
		WR_N = ~w;
		RD_N = w;
		cyc(5);
		q = DOUT;
		chk({7'h00, DOUT_OE}, {7'h00, ~w});
		{CS_N, WR_N, RD_N} = 3'h7;
		cyc(4);
	endtask
	task automatic wr(input logic [2:0] s, input logic [7:0] d);
		bus(s, 1'b1, d);
	endtask
	task automatic rdc(input logic [2:0] s, input logic [7:0] x);
		bus(s, 1'b0, 8'h00);
		chk(q, x);
		chk({7'h00, DOUT_OE}, 8'h00);
	endtask
	task automatic wait_tx(input int n);
		for (int i = 0; i < 8000 && m.got_q.size() < n; i++) @(posedge CLOCK);
		#1;
		if (m.got_q.size() < n) begin
			fail_count++;
			finish_test();
		end
	endtask
	task automatic tx_chk(input logic [7:0] x);
		chk(m.got_q.pop_front(), x);
		chk({7'h00, m.err_q.pop_front()}, 8'h00);
	endtask
	task automatic t_reset();
		rdc(3'h3, 8'h00);
		rdc(3'h4, 8'h00);
		rdc(3'h1, 8'h00);
		rdc(3'h7, 8'h00);
		rdc(3'h5, 8'h60);
	endtask
	task automatic t_decode();
		wr(3'h7, 8'hA5);
		rdc(3'h7, 8'hA5);
		wr(3'h1, 8'h05);
		wr(3'h3, 8'h83);
		wr(3'h0, 8'h5A);
		wr(3'h1, 8'h3C);
		rdc(3'h0, 8'h5A);
		rdc(3'h1, 8'h3C);
		wr(3'h3, 8'h03);
		rdc(3'h1, 8'h05);
		rdc(3'h3, 8'h03);
		wr(3'h3, 8'h83);
		rdc(3'h0, 8'h5A);
		wr(3'h0, 8'h01);
		wr(3'h1, 8'h00);
		wr(3'h3, 8'h03);
		wr(3'h5, 8'hFF);
		rdc(3'h5, 8'h60);
		wr(3'h1, 8'h00);
	endtask
	task automatic t_mctl();
		wr(3'h4, 8'h01);
		chk({6'h00, DTR_N, RTS_N}, 8'h01);
		wr(3'h4, 8'h02);
		chk({6'h00, DTR_N, RTS_N}, 8'h02);
		rdc(3'h4, 8'h02);
		wr(3'h4, 8'h00);
		chk({6'h00, DTR_N, RTS_N}, 8'h03);
	endtask
	task automatic t_mstat();
		wr(3'h6, 8'hFF);
		for (int p = 0; p < 16; p++) begin
			{CD_N, RI_N, DSR_N, CTS_N} = p[3:0];
			cyc(4);
			bus(3'h6, 1'b0, 8'h00);
			chk({4'h0, q[7:4]}, {4'h0, ~p[3:0]});
		end
		wr(3'h1, 8'h08);
		RI_N = 1'b0;
		cyc(6);
		chk({7'h00, INT}, 8'h00);
		RI_N = 1'b1;
		cyc(6);
		chk({7'h00, INT}, 8'h01);
		bus(3'h6, 1'b0, 8'h00);
		chk({7'h00, INT}, 8'h00);
		wr(3'h1, 8'h00);
	endtask
	// clear-to-send stays inactive here, yet frames must still go out
	task automatic t_tx();
		wr(3'h2, 8'h07);
		wr(3'h0, 8'h55);
		wr(3'h0, 8'hA3);
		wr(3'h0, 8'h0F);
		wait_tx(3);
		tx_chk(8'h55);
		tx_chk(8'hA3);
		tx_chk(8'h0F);
		wr(3'h3, 8'h1B);
		par_en = 1'b1;
		wr(3'h0, 8'h96);
		wr(3'h0, 8'h01);
		wait_tx(2);
		tx_chk(8'h96);
		tx_chk(8'h01);
	endtask
	task automatic t_rx();
		m.send_byte(8'h5A, 1'b0);
		cyc(24);
		rdc(3'h5, 8'h61);
		rdc(3'h0, 8'h5A);
		m.send_byte(8'hC3, 1'b1);
		cyc(24);
		rdc(3'h5, 8'h65);
		rdc(3'h0, 8'hC3);
		rdc(3'h5, 8'h60);
	endtask
	task automatic t_loop();
		logic hi;
		hi = 1'b1;
		wr(3'h4, 8'h10);
		m.rx = 1'b0;
		wr(3'h0, 8'h3C);
		for (int i = 0; i < 250; i++) begin
			cyc(1);
			hi = hi & TX;
		end
		chk({7'h00, hi}, 8'h01);
		rdc(3'h5, 8'h61);
		rdc(3'h0, 8'h3C);
		m.rx = 1'b1;
		wr(3'h4, 8'h00);
		wr(3'h0, 8'h7E);
		wait_tx(1);
		tx_chk(8'h7E);
	endtask
	task automatic t_queue();
		par_en = 1'b0;
		wr(3'h3, 8'h03);
		wr(3'h2, 8'hC7);
		wr(3'h1, 8'h01);
		for (int i = 1; i <= 17; i++) begin
			m.send_byte(i[7:0], 1'b0);
			cyc(24);
			if (i == 13 || i == 14) chk({7'h00, INT}, {7'h00, i == 14});
		end
		rdc(3'h2, 8'hC4);
		bus(3'h5, 1'b0, 8'h00);
		chk({7'h00, q[1]}, 8'h01);
		// step the threshold down to 8, 4 and 1 while the queue drains
		for (int i = 1; i <= 16; i++) begin
			if (i == 10 || i == 14) chk({7'h00, INT}, 8'h00);
			if (i == 1 || i == 10 || i == 14) wr(3'h2, (i == 1) ? 8'h81 : (i == 10) ? 8'h41 : 8'h01);
			chk({7'h00, INT}, 8'h01);
			rdc(3'h0, i[7:0]);
		end
		chk({7'h00, INT}, 8'h00);
		rdc(3'h5, 8'h60);
		wr(3'h1, 8'h00);
	endtask
	initial begin
		CLOCK = 1'b0;
		RESETN = 1'b0;
		{CS_N, RD_N, WR_N, CTS_N, DSR_N, RI_N, CD_N} = 7'h7F;
		{SEL, DIN, par_en} = 12'h000;
		fail_count = 0;
		num_checks = 0;
		cyc(20);
		chk({5'h00, TX, DTR_N, RTS_N}, 8'h07);
		RESETN = 1'b1;
		cyc(1);
		t_reset();
		t_decode();
		t_mctl();
		t_mstat();
		t_tx();
		t_rx();
		t_loop();
		t_queue();
		finish_test();
	end
endmodule
`default_nettype wire
